// file: hw/usr_pkg.sv
// Package for the four-bit universal shift register
package usr_pkg;

  localparam int WIDTH = 4;
  localparam int BUF_DEPTH = 2;
  localparam logic [WIDTH-1:0] STAGE_RESET = 4'h0;

  typedef enum logic [1:0]
  {
    MODE_LOAD = 2'b00,
    MODE_TO_STAGE0 = 2'b01,
    MODE_TO_STAGE3 = 2'b10,
    MODE_HOLD = 2'b11
  } usr_mode_type;

endpackage : usr_pkg

// file: hw/usr_out_buf.sv
// Two-entry output buffer with valid and ready on both sides
`timescale 1ns/1ps
module usr_out_buf #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready_o = (count_ff != (PW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o = mem_ff[rd_ptr_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : usr_out_buf

// file: hw/usr_shift_reg.sv
// Four-bit universal shift register with buffered snapshot output
//
// Summary of operation
// - All stages update together on rising edge
// - Only the select pair chooses the operation
// - Select 00 loads parallel inputs per stage
// - Select 01 shifts toward stage 0
// - Select 10 shifts toward stage 3
// - Hold keeps every stage, inputs ignored
// - Stage outputs show new contents after the edge
`timescale 1ns/1ps
module usr_shift_reg
  import usr_pkg::*;
#(
  parameter int WIDTH_P = usr_pkg::WIDTH
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic mode_select_first_i,
  input wire logic mode_select_second_i,
  input wire logic left_serial_in_i,
  input wire logic right_serial_in_i,
  input wire logic parallel_in_bit0_i,
  input wire logic parallel_in_bit1_i,
  input wire logic parallel_in_bit2_i,
  input wire logic parallel_in_bit3_i,
  output logic stage_out_bit0_o,
  output logic stage_out_bit1_o,
  output logic stage_out_bit2_o,
  output logic stage_out_bit3_o,
  output logic snap_valid_o,
  input wire logic snap_ready_i,
  output logic [3:0] snap_data_o
);
  import usr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] stage_ff;
  logic [3:0] nxt_stage;
  logic [3:0] par_in;
  usr_mode_type mode;
  logic buf_ready;
  logic buf_valid;
  logic [3:0] buf_data;
  logic snap_valid_ff;
  logic [3:0] snap_data_ff;

  assign par_in = {parallel_in_bit3_i, parallel_in_bit2_i, parallel_in_bit1_i,
                   parallel_in_bit0_i};
  assign mode = usr_mode_type'({mode_select_first_i, mode_select_second_i});

  always_comb
  begin
    unique case (mode)
      MODE_LOAD: nxt_stage = par_in;
      MODE_TO_STAGE0: nxt_stage = {right_serial_in_i, stage_ff[3:1]};
      MODE_TO_STAGE3: nxt_stage = {stage_ff[2:0], left_serial_in_i};
      MODE_HOLD: nxt_stage = stage_ff;
    endcase
  end

  // Stages step one operation per edge; a buffer stall never holds them back
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      stage_ff <= STAGE_RESET;
    end
    else
    begin
      stage_ff <= nxt_stage;
    end
  end

  assign stage_out_bit0_o = stage_ff[0];
  assign stage_out_bit1_o = stage_ff[1];
  assign stage_out_bit2_o = stage_ff[2];
  assign stage_out_bit3_o = stage_ff[3];

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot stream: each non-hold update offers the new contents
  logic snap_push;
  assign snap_push = (mode != MODE_HOLD) && !srst_i;

  usr_out_buf #(
    .WIDTH(4),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .in_valid_i(snap_push),
    .in_ready_o(buf_ready),
    .in_data_i(nxt_stage),
    .out_valid_o(buf_valid),
    .out_ready_i(snap_ready_i || !snap_valid_ff),
    .out_data_o(buf_data)
  );

  // Output register keeps snap ports flop-driven; words drop only when full
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      snap_valid_ff <= 1'b0;
      snap_data_ff <= STAGE_RESET;
    end
    else if (snap_ready_i || !snap_valid_ff)
    begin
      snap_valid_ff <= buf_valid;
      snap_data_ff <= buf_data;
    end
  end

  assign snap_valid_o = snap_valid_ff;
  assign snap_data_o = snap_data_ff;

  ////////////////////////////////////////////////////////////////////////////
  property p_load;
    @(posedge clk_i) disable iff (srst_i)
    (mode == MODE_LOAD) |=> (stage_ff == $past(par_in));
  endproperty
  a_load: assert property (p_load) else $error("load wrong");

  property p_to0;
    @(posedge clk_i) disable iff (srst_i)
    (mode == MODE_TO_STAGE0) |=> (stage_ff == {$past(right_serial_in_i), $past(stage_ff[3:1])});
  endproperty
  a_to0: assert property (p_to0) else $error("shift to stage0 wrong");

  property p_to3;
    @(posedge clk_i) disable iff (srst_i)
    (mode == MODE_TO_STAGE3) |=> (stage_ff == {$past(stage_ff[2:0]), $past(left_serial_in_i)});
  endproperty
  a_to3: assert property (p_to3) else $error("shift to stage3 wrong");

  property p_hold;
    @(posedge clk_i) disable iff (srst_i)
    (mode == MODE_HOLD) [*2] |=> $stable(stage_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("hold changed stages");

  property p_hold_code;
    @(posedge clk_i) disable iff (srst_i)
    (mode_select_first_i && mode_select_second_i) |=> (stage_ff == $past(stage_ff));
  endproperty
  a_hold_code: assert property (p_hold_code) else $error("11 not hold");

  property p_outs;
    @(posedge clk_i) disable iff (srst_i)
    1'b1 |=> ({stage_out_bit3_o, stage_out_bit2_o, stage_out_bit1_o, stage_out_bit0_o}
              == $past(nxt_stage));
  endproperty
  a_outs: assert property (p_outs) else $error("outputs not new contents");

  // Raw pins, so a swapped select pair is caught as well as a bad decode
  property p_sel_only;
    @(posedge clk_i) disable iff (srst_i)
    (!mode_select_first_i && mode_select_second_i) |=>
      (stage_ff[2:0] == $past(stage_ff[3:1]));
  endproperty
  a_sel_only: assert property (p_sel_only) else $error("select pins mis-decoded");

  property p_snap_hold;
    @(posedge clk_i) disable iff (srst_i)
    (snap_valid_o && !snap_ready_i) |=> (snap_valid_o && $stable(snap_data_o));
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("snapshot lost under stall");

  property p_load_pins;
    @(posedge clk_i) disable iff (srst_i)
    (!mode_select_first_i && !mode_select_second_i) |=>
      (stage_out_bit0_o == $past(parallel_in_bit0_i)) &&
      (stage_out_bit1_o == $past(parallel_in_bit1_i)) &&
      (stage_out_bit2_o == $past(parallel_in_bit2_i)) &&
      (stage_out_bit3_o == $past(parallel_in_bit3_i));
  endproperty
  a_load_pins: assert property (p_load_pins) else $error("parallel load pins wrong");

  property p_to3_pins;
    @(posedge clk_i) disable iff (srst_i)
    (mode_select_first_i && !mode_select_second_i) |=>
      (stage_ff[3:1] == $past(stage_ff[2:0]));
  endproperty
  a_to3_pins: assert property (p_to3_pins) else $error("select pins to stage3 wrong");

  property p_push_offer;
    @(posedge clk_i) disable iff (srst_i)
    (snap_push && buf_ready) |=> buf_valid;
  endproperty
  a_push_offer: assert property (p_push_offer) else $error("update not offered");

  property p_snap_reload;
    @(posedge clk_i) disable iff (srst_i)
    (buf_valid && (snap_ready_i || !snap_valid_o)) |=>
      (snap_valid_o && (snap_data_o == $past(buf_data)));
  endproperty
  a_snap_reload: assert property (p_snap_reload) else $error("snapshot not forwarded");

  property p_snap_idle;
    @(posedge clk_i) disable iff (srst_i)
    (!buf_valid && (snap_ready_i || !snap_valid_o)) |=> !snap_valid_o;
  endproperty
  a_snap_idle: assert property (p_snap_idle) else $error("stale snapshot shown");

  property p_hold_quiet;
    @(posedge clk_i) disable iff (srst_i)
    ((mode == MODE_HOLD) && !buf_valid) |=> !buf_valid;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("hold pushed a snapshot");

  property p_reset_clear;
    @(posedge clk_i)
    srst_i |=> ((stage_ff == STAGE_RESET) && !snap_valid_o);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

  c_load: cover property (@(posedge clk_i) disable iff (srst_i) mode == MODE_LOAD);
  c_shift: cover property (@(posedge clk_i) disable iff (srst_i)
    mode == MODE_TO_STAGE0 ##1 mode == MODE_TO_STAGE3);
  c_stall: cover property (@(posedge clk_i) disable iff (srst_i) !buf_ready);
  c_hold: cover property (@(posedge clk_i) disable iff (srst_i)
    mode == MODE_HOLD ##1 mode == MODE_HOLD);
  c_drop: cover property (@(posedge clk_i) disable iff (srst_i) snap_push && !buf_ready);

endmodule : usr_shift_reg

// file: sim/usr_sink.sv
// Snapshot consumer that the bench can stall
`timescale 1ns/1ps
module usr_sink (
  input wire logic stall_i,
  output logic snap_ready_o
);
  // Ready follows the bench, so a stall lands off the sampling edge
  assign snap_ready_o = !stall_i;
endmodule : usr_sink

// file: sim/tb_top.sv
// Self-checking bench for the universal shift register
`timescale 1ns/1ps
module tb_top;
  import usr_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  usr_mode_type m = MODE_HOLD;
  logic l = 1'b0;
  logic r = 1'b0;
  logic stall = 1'b0;
  logic [3:0] d = 4'h0;
  logic [3:0] exp_q = 4'h0;
  logic [3:0] q;
  logic [3:0] sd;
  logic sv;
  logic srdy;
  int n_fail = 0;
  int n_compared = 0;
  usr_shift_reg u_dut (.clk_i(clk_i), .srst_i(srst_i),
    .mode_select_first_i(m[1]), .mode_select_second_i(m[0]),
    .left_serial_in_i(l), .right_serial_in_i(r),
    .parallel_in_bit0_i(d[0]), .parallel_in_bit1_i(d[1]),
    .parallel_in_bit2_i(d[2]), .parallel_in_bit3_i(d[3]),
    .stage_out_bit0_o(q[0]), .stage_out_bit1_o(q[1]),
    .stage_out_bit2_o(q[2]), .stage_out_bit3_o(q[3]),
    .snap_valid_o(sv), .snap_ready_i(srdy), .snap_data_o(sd));
  usr_sink u_sink (.stall_i(stall), .snap_ready_o(srdy));
  //////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic check(string what, logic [3:0] seen, logic [3:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", what, want, seen);
    end
  endtask : check
  // Stages must not move when inputs change between edges
  task automatic step(usr_mode_type mo, logic [3:0] dd, logic ll, logic rr);
    @(negedge clk_i);
    m = mo;
    d = dd;
    l = ll;
    r = rr;
    #1 check("between", q, exp_q);
    case (mo)
      MODE_LOAD: exp_q = dd;
      MODE_TO_STAGE0: exp_q = {rr, exp_q[3:1]};
      MODE_TO_STAGE3: exp_q = {exp_q[2:0], ll};
      default: exp_q = exp_q;
    endcase
    @(posedge clk_i);
    #1 check("stages", q, exp_q);
  endtask : step
  task automatic get(logic [3:0] want);
    int i;
    i = 0;
    while (sv !== 1'b1 && i < 8)
    begin
      @(negedge clk_i);
      i++;
    end
    if (sv !== 1'b1)
    begin
      n_fail++;
      wrap_up();
    end
    else
    begin
      check("snap", sd, want);
      @(negedge clk_i);
    end
  endtask : get
  task automatic t_load();
    step(MODE_LOAD, 4'hA, 1'b1, 1'b1);
    step(MODE_LOAD, 4'h5, 1'b0, 1'b0);
  endtask : t_load
  task automatic t_shift();
    step(MODE_TO_STAGE0, 4'hF, 1'b0, 1'b1);
    step(MODE_TO_STAGE0, 4'h0, 1'b1, 1'b0);
    step(MODE_TO_STAGE3, 4'hF, 1'b1, 1'b0);
    step(MODE_TO_STAGE3, 4'h0, 1'b0, 1'b1);
  endtask : t_shift
  task automatic t_hold();
    step(MODE_HOLD, ~exp_q, 1'b1, 1'b1);
    step(MODE_HOLD, exp_q, 1'b0, 1'b0);
    step(MODE_HOLD, 4'hF, 1'b1, 1'b0);
  endtask : t_hold
  // Mid-run reset clears stages and drops a pending snapshot
  task automatic t_reset();
    step(MODE_LOAD, 4'hC, 1'b0, 1'b1);
    @(negedge clk_i);
    srst_i = 1'b1;
    m = MODE_HOLD;
    exp_q = STAGE_RESET;
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    check("reset", q, exp_q);
    check("reset valid", {3'h0, sv}, 4'h0);
  endtask : t_reset
  // Stalled consumer: three words kept, the fourth is dropped
  task automatic t_snap();
    @(negedge clk_i);
    stall = 1'b1;
    step(MODE_LOAD, 4'h3, 1'b0, 1'b0);
    step(MODE_LOAD, 4'h4, 1'b0, 1'b0);
    step(MODE_LOAD, 4'h5, 1'b0, 1'b0);
    step(MODE_LOAD, 4'h6, 1'b0, 1'b0);
    step(MODE_HOLD, 4'h0, 1'b0, 1'b0);
    check("valid", {3'h0, sv}, 4'h1);
    @(negedge clk_i);
    stall = 1'b0;
    get(4'h3);
    get(4'h4);
    get(4'h5);
    repeat (3) @(negedge clk_i);
    check("valid", {3'h0, sv}, 4'h0);
  endtask : t_snap
  //////////////////////////////////////////////////////////////////
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (16) @(negedge clk_i);
    srst_i = 1'b0;
    t_load();
    t_shift();
    t_hold();
    t_reset();
    t_snap();
    wrap_up();
  end
endmodule : tb_top
